/* File: core/irb2_pkg.sv */
// constants shared by the second initialization register bank
package irb2_pkg;

   // ------------------------------------------------------------
   // serial frame layout
   // ------------------------------------------------------------
   localparam int             DATA_W       = 16;
   localparam int             ADDR_W       = 7;
   localparam int             FRAME_W      = 24;
   localparam int             HDR_W        = 8;
   localparam int             RD_FLAG_BIT  = 23;
   localparam int             ADDR_MSB     = 22;
   localparam int             ADDR_LSB     = 16;
   localparam logic [4:0]     FRAME_BITS   = 5'h18;
   localparam logic [4:0]     HEADER_BITS  = 5'h08;
   localparam logic [4:0]     BIT_ONE      = 5'h01;

   // ------------------------------------------------------------
   // register offsets, reset values, flag positions
   // ------------------------------------------------------------
   localparam logic [6:0]     OFF_INIT_A   = 7'h0a;
   localparam logic [6:0]     OFF_INIT_B   = 7'h12;
   localparam logic [6:0]     OFF_INIT_C   = 7'h13;
   localparam logic [15:0]    RST_INIT_A   = 16'h0000;
   localparam logic [15:0]    RST_INIT_B   = 16'h0000;
   localparam logic [15:0]    RST_INIT_C   = 16'h0000;
   localparam logic [15:0]    READ_UNMAPPED = 16'h0000;
   localparam int             FLAG_A_BIT   = 14;
   localparam int             FLAG_B_BIT   = 6;
   localparam int             FLAG_C_BIT   = 15;

endpackage

/* File: core/irb2_regbank.sv */
// second initialization register bank behind the serial configuration port
`timescale 1ns/10ps

// Behaviour
// - Offset 0x12 bit 6 is an init flag that stores and returns what the host wrote.
// - Offset 0x13 bit 15 is an init flag the host sets during init and clears afterwards.
// - Offset 0x0A bit 14 is an init flag the host sets during init and clears afterwards.
// - After reset offset 0x12 reads all zeros.
// - After reset offset 0x13 reads all zeros.
// - After reset offset 0x0A reads all zeros.
module irb2_regbank (
   // clock and reset
   input  wire logic   clock,
   input  wire logic   rstn,
   // serial configuration port
   input  wire logic   csn,
   input  wire logic   sclk,
   input  wire logic   sdi,
   output logic        sdo,
   output logic        sdoEn,
   // initialization flags to device logic
   output logic        initFlagA,
   output logic        initFlagB,
   output logic        initFlagC
);

   typedef struct packed {
      logic [irb2_pkg::DATA_W-1:0]   regA;
      logic [irb2_pkg::DATA_W-1:0]   regB;
      logic [irb2_pkg::DATA_W-1:0]   regC;
      logic [irb2_pkg::DATA_W-1:0]   txShift;
      logic                          sdo;
      logic                          sdoEn;
   } irb2_bank_s;

   irb2_bank_s                       st;
   irb2_bank_s                       next_st;
   logic                             hdrValid;
   logic                             wordValid;
   logic                             fallPulse;
   logic [irb2_pkg::FRAME_W-1:0]     word;
   logic                             rdFlag;
   logic [irb2_pkg::ADDR_W-1:0]      addr;
   logic [irb2_pkg::DATA_W-1:0]      wrData;
   logic                             wrCommit;

   // ------------------------------------------------------------
   // serial receiver
   // ------------------------------------------------------------
   irb2_spi_shift u_shift (
      .clock     (clock),
      .rstn      (rstn),
      .csn       (csn),
      .sclk      (sclk),
      .sdi       (sdi),
      .hdrValid  (hdrValid),
      .wordValid (wordValid),
      .fallPulse (fallPulse),
      .word      (word)
   );

   // header sits in the low byte when hdrValid, in the top byte when wordValid
   assign rdFlag   = hdrValid ? word[irb2_pkg::HDR_W-1] : word[irb2_pkg::RD_FLAG_BIT];
   assign addr     = hdrValid ? word[irb2_pkg::ADDR_W-1:0]
                              : word[irb2_pkg::ADDR_MSB:irb2_pkg::ADDR_LSB];
   assign wrData   = word[irb2_pkg::DATA_W-1:0];
   assign wrCommit = wordValid && !rdFlag;

   function automatic logic [irb2_pkg::DATA_W-1:0] read_mux(
      input logic [irb2_pkg::ADDR_W-1:0] a,
      input irb2_bank_s                  s
   );
      logic [irb2_pkg::DATA_W-1:0] v;
      v = irb2_pkg::READ_UNMAPPED;
      if (a == irb2_pkg::OFF_INIT_A) begin
         v = s.regA;
      end else if (a == irb2_pkg::OFF_INIT_B) begin
         v = s.regB;
      end else if (a == irb2_pkg::OFF_INIT_C) begin
         v = s.regC;
      end
      return v;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.sdoEn = !csn;
      if (hdrValid) begin
         // read data returns all 16 bits as stored
         next_st.txShift = rdFlag ? read_mux(addr, st) : '0;
      end else if (fallPulse) begin
         // first falling edge after the header presents the data msb
         next_st.sdo     = st.txShift[irb2_pkg::DATA_W-1];
         next_st.txShift = {st.txShift[irb2_pkg::DATA_W-2:0], 1'b0};
      end
      if (csn) begin
         next_st.sdo = 1'b0;
      end
      if (wrCommit) begin
         // whole word is stored, reserved bits included
         unique case (addr)
            irb2_pkg::OFF_INIT_A: next_st.regA = wrData;
            irb2_pkg::OFF_INIT_B: next_st.regB = wrData;
            irb2_pkg::OFF_INIT_C: next_st.regC = wrData;
            default: begin
               // unmapped offsets drop the write
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         st <= '{regA:    irb2_pkg::RST_INIT_A,
                 regB:    irb2_pkg::RST_INIT_B,
                 regC:    irb2_pkg::RST_INIT_C,
                 txShift: '0,
                 sdo:     1'b0,
                 sdoEn:   1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign sdo       = st.sdo;
   assign sdoEn     = st.sdoEn;
   assign initFlagA = st.regA[irb2_pkg::FLAG_A_BIT];
   assign initFlagB = st.regB[irb2_pkg::FLAG_B_BIT];
   assign initFlagC = st.regC[irb2_pkg::FLAG_C_BIT];

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_rst_a;
      @(posedge clock) disable iff (!rstn)
      $rose(rstn) |-> (st.regA == irb2_pkg::RST_INIT_A) && !initFlagA;
   endproperty
   a_rst_a: assert property (p_rst_a)
      else $error("reg 0x0a not cleared by reset");

   property p_rst_b;
      @(posedge clock) disable iff (!rstn)
      $rose(rstn) |-> (st.regB == irb2_pkg::RST_INIT_B) && !initFlagB;
   endproperty
   a_rst_b: assert property (p_rst_b)
      else $error("reg 0x12 not cleared by reset");

   property p_rst_c;
      @(posedge clock) disable iff (!rstn)
      $rose(rstn) |-> (st.regC == irb2_pkg::RST_INIT_C) && !initFlagC;
   endproperty
   a_rst_c: assert property (p_rst_c)
      else $error("reg 0x13 not cleared by reset");

   property p_wr_b;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_B)
         |=> initFlagB == $past(wrData[irb2_pkg::FLAG_B_BIT]);
   endproperty
   a_wr_b: assert property (p_wr_b)
      else $error("flag in 0x12 does not follow write");

   property p_wr_c;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_C)
         |=> initFlagC == $past(wrData[irb2_pkg::FLAG_C_BIT]);
   endproperty
   a_wr_c: assert property (p_wr_c)
      else $error("flag in 0x13 does not follow write");

   property p_wr_a;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_A)
         |=> initFlagA == $past(wrData[irb2_pkg::FLAG_A_BIT]);
   endproperty
   a_wr_a: assert property (p_wr_a)
      else $error("flag in 0x0a does not follow write");

   property p_full_word;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_B) |=> st.regB == $past(wrData);
   endproperty
   a_full_word: assert property (p_full_word)
      else $error("reg 0x12 lost bits of the written word");

   property p_hold;
      @(posedge clock) disable iff (!rstn)
      !wrCommit |=> $stable(st.regA) && $stable(st.regB) && $stable(st.regC);
   endproperty
   a_hold: assert property (p_hold)
      else $error("bank changed without a write frame");

   // reserved bits of 0x0a and 0x13 are kept too, not only the flag
   property p_full_word_a;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_A) |=> st.regA == $past(wrData);
   endproperty
   a_full_word_a: assert property (p_full_word_a)
      else $error("reg 0x0a lost bits of the written word");

   property p_full_word_c;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr == irb2_pkg::OFF_INIT_C) |=> st.regC == $past(wrData);
   endproperty
   a_full_word_c: assert property (p_full_word_c)
      else $error("reg 0x13 lost bits of the written word");

   // a write to a foreign offset must not alias onto the bank
   property p_unmapped;
      @(posedge clock) disable iff (!rstn)
      (wrCommit && addr != irb2_pkg::OFF_INIT_A && addr != irb2_pkg::OFF_INIT_B
         && addr != irb2_pkg::OFF_INIT_C)
         |=> $stable(st.regA) && $stable(st.regB) && $stable(st.regC);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("write to an unmapped offset changed the bank");

   // deselected port neither drives nor shows stale data
   property p_sdo_idle;
      @(posedge clock) disable iff (!rstn)
      csn |=> !sdo && !sdoEn;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle)
      else $error("serial output active while deselected");

   property p_sdo_en;
      @(posedge clock) disable iff (!rstn)
      !csn |=> sdoEn;
   endproperty
   a_sdo_en: assert property (p_sdo_en)
      else $error("serial output not enabled while selected");

endmodule

/* File: core/irb2_spi_shift.sv */
// serial configuration port receiver: edge detect, bit count, shift register
`timescale 1ns/10ps
module irb2_spi_shift (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rstn,
   // serial pins, already synchronous to clock
   input  wire logic                          csn,
   input  wire logic                          sclk,
   input  wire logic                          sdi,
   // frame events
   output logic                               hdrValid,
   output logic                               wordValid,
   output logic                               fallPulse,
   output logic [irb2_pkg::FRAME_W-1:0]       word
);

   typedef struct packed {
      logic                             prevSclk;
      logic [4:0]                       bitCount;
      logic [irb2_pkg::FRAME_W-1:0]     shift;
      logic                             hdrValid;
      logic                             wordValid;
      logic                             fallPulse;
   } irb2_shift_s;

   irb2_shift_s st;
   irb2_shift_s next_st;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st           = st;
      next_st.prevSclk  = sclk;
      next_st.hdrValid  = 1'b0;
      next_st.wordValid = 1'b0;
      next_st.fallPulse = 1'b0;
      if (csn) begin
         // deselect aborts any partial frame
         next_st.bitCount = '0;
      end else if (sclk && !st.prevSclk) begin
         // bits past the frame length are ignored until deselect
         if (st.bitCount < irb2_pkg::FRAME_BITS) begin
            next_st.shift    = {st.shift[irb2_pkg::FRAME_W-2:0], sdi};
            next_st.bitCount = st.bitCount + irb2_pkg::BIT_ONE;
            next_st.hdrValid  = (st.bitCount == irb2_pkg::HEADER_BITS - irb2_pkg::BIT_ONE);
            next_st.wordValid = (st.bitCount == irb2_pkg::FRAME_BITS - irb2_pkg::BIT_ONE);
         end
      end else if (!sclk && st.prevSclk) begin
         next_st.fallPulse = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign hdrValid  = st.hdrValid;
   assign wordValid = st.wordValid;
   assign fallPulse = st.fallPulse;
   assign word      = st.shift;

endmodule

/* File: verif/irb2_host_model.sv */
// configuration host model for the serial port of the bank
`timescale 1ns/10ps
module irb2_host_model (
   // clock
   input  wire logic clock,
   // serial pins
   output logic      csn,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdoEn
);
   // phases well above the 2-cycle minimum, leaving room for the sdo delay
   localparam int HALF = 5;
   initial begin
      csn  = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
   end
   // words go out as given; callers keep non-flag bits zero except on purpose
   // bank-one access key is never touched from here
   task automatic xfer(input logic [23:0] f, input int nbits, output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clock);
      csn <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(posedge clock);
         sclk <= 1'b0;
         sdi  <= f[23-i];
         repeat (HALF) @(posedge clock);
         if (i >= 8) begin
            rd[23-i] = sdo;
         end
         sclk <= 1'b1;
         repeat (HALF - 1) @(posedge clock);
      end
      @(posedge clock);
      sclk <= 1'b0;
      repeat (2) @(posedge clock);
      csn <= 1'b1;
      // released data line shows no stale level
      sdi <= ~sdi;
      repeat (3) @(posedge clock);
   endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the second initialization register bank
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [6:0]  off;
      logic [15:0] wr;
      logic [15:0] rdExp;
      logic [2:0]  flags;
   } irb2_row_s;
   logic        clock;
   logic        rstn;
   logic        csn;
   logic        sclk;
   logic        sdi;
   logic        sdo;
   logic        sdoEn;
   logic        initFlagA;
   logic        initFlagB;
   logic        initFlagC;
   logic [15:0] rd;
   int          failCount;
   int          checks;
   int          cycles;
   // flags ordered A, B, C
   irb2_row_s   rows [9] = '{
      '{7'h12, 16'h0040, 16'h0040, 3'b010},
      '{7'h13, 16'h8000, 16'h8000, 3'b011},
      '{7'h0a, 16'h4000, 16'h4000, 3'b111},
      '{7'h12, 16'h0000, 16'h0000, 3'b101},
      '{7'h13, 16'h0000, 16'h0000, 3'b100},
      '{7'h0a, 16'h0000, 16'h0000, 3'b000},
      '{7'h13, 16'h7fff, 16'h7fff, 3'b000},
      '{7'h0a, 16'hbfff, 16'hbfff, 3'b000},
      '{7'h20, 16'hffff, 16'h0000, 3'b000}};

   irb2_regbank DUT (.clock(clock), .rstn(rstn), .csn(csn), .sclk(sclk), .sdi(sdi),
      .sdo(sdo), .sdoEn(sdoEn), .initFlagA(initFlagA), .initFlagB(initFlagB),
      .initFlagC(initFlagC));
   irb2_host_model host (.clock(clock), .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo),
      .sdoEn(sdoEn));

   initial begin
      clock = 1'b0;
      rstn  = 1'b0;
   end
   always #12.5 clock = ~clock;

   task automatic close_out();
      if (failCount == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic doReset();
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
   endtask

   // all three read zero, flags low and port idle after reset
   task automatic zeroCheck();
      logic [6:0] offs [3] = '{7'h12, 7'h13, 7'h0a};
      chk({13'h0000, initFlagA, initFlagB, initFlagC}, 16'h0000);
      chk({14'h0000, sdo, sdoEn}, 16'h0000);
      foreach (offs[k]) begin
         host.xfer({1'b1, offs[k], 16'h0000}, 24, rd);
         chk(rd, 16'h0000);
      end
   endtask

   // hang guard: the full run needs roughly 7100 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         close_out();
      end
   end

   initial begin
      doReset();
      zeroCheck();
      foreach (rows[k]) begin
         host.xfer({1'b0, rows[k].off, rows[k].wr}, 24, rd);
         chk({13'h0000, initFlagA, initFlagB, initFlagC}, {13'h0000, rows[k].flags});
         host.xfer({1'b1, rows[k].off, 16'h0000}, 24, rd);
         chk(rd, rows[k].rdExp);
      end
      // aborted write leaves the stored word alone
      host.xfer({1'b0, 7'h12, 16'h0040}, 24, rd);
      host.xfer({1'b0, 7'h12, 16'h0000}, 20, rd);
      host.xfer({1'b1, 7'h12, 16'h0000}, 24, rd);
      chk(rd, 16'h0040);
      chk({15'h0000, initFlagB}, 16'h0001);
      // second reset with every flag set
      host.xfer({1'b0, 7'h13, 16'h8000}, 24, rd);
      host.xfer({1'b0, 7'h0a, 16'h4000}, 24, rd);
      chk({13'h0000, initFlagA, initFlagB, initFlagC}, 16'h0007);
      doReset();
      zeroCheck();
      close_out();
   end
endmodule
